// *** rtl/apr_pkg.sv ***
/*
 * apr_pkg: constants, carrier structs and state struct for the
 * auto-negotiation page register bank.
 * assumes a clause 22 management frame decoder sits outside and hands
 * over one decoded register access at a time.
 */
package apr_pkg;

    // register indices on the clause 22 management port
    localparam logic [4:0]  APR_ADDR_ADV      = 5'h04;
    localparam logic [4:0]  APR_ADDR_LP_BASE  = 5'h05;
    localparam logic [4:0]  APR_ADDR_EXP      = 5'h06;
    localparam logic [4:0]  APR_ADDR_TX_NP    = 5'h07;
    localparam logic [4:0]  APR_ADDR_LP_NP    = 5'h08;

    // local advertisement layout
    localparam int          APR_ADV_NEXT_PAGE = 15;
    localparam int          APR_ADV_ACK       = 14;
    localparam int          APR_ADV_RFAULT    = 13;
    localparam int          APR_ADV_XNP       = 12;
    localparam int          APR_ADV_ASYM      = 11;
    localparam int          APR_ADV_PAUSE     = 10;
    localparam int          APR_ADV_T4        = 9;
    localparam logic [15:0] APR_ADV_RESET     = 16'h1DE1;
    localparam logic [15:0] APR_ADV_WMASK     = 16'hBDFF;

    // partner base page layout
    localparam int          APR_LP_NEXT_PAGE  = 15;

    // expansion layout
    localparam int          APR_EXP_PD_FAULT  = 4;
    localparam int          APR_EXP_LP_NP     = 3;
    localparam int          APR_EXP_LOC_NP    = 2;
    localparam int          APR_EXP_PAGE_RX   = 1;
    localparam int          APR_EXP_LP_AN     = 0;

    // transmit next page layout
    localparam int          APR_NP_TOGGLE     = 11;
    localparam logic [15:0] APR_NP_RESET      = 16'h2001;
    localparam logic [15:0] APR_NP_WMASK      = 16'hB7FF;

    localparam logic [15:0] APR_ZERO16        = 16'h0000;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } apr_mgmt_t;

    typedef struct packed {
        logic soft_reset;
        logic restart;
        logic pd_exit;
        logic link_down;
    } apr_ctl_t;

    typedef struct packed {
        logic        base_valid;
        logic        np_valid;
        logic [15:0] word;
        logic        par_fault;
        logic        an_able;
        logic        base_sent;
        logic        np_sent;
    } apr_rx_t;

    typedef struct packed {
        logic [15:0] adv;
        logic [15:0] adv_eff;
        logic [15:0] lp_base;
        logic [15:0] lp_np;
        logic [15:0] tx_np;
        logic        toggle;
        logic        pd_fault;
        logic        lp_np_able;
        logic        page_rx;
        logic [15:0] rdata;
        logic        rvalid;
        logic        restart;
        logic        boot_done;
    } apr_state_t;

endpackage : apr_pkg

// *** rtl/apr_regs.sv ***
/*
 * apr_regs: auto-negotiation page registers (advertisement, partner
 * base page, expansion, transmit next page, partner next page).
 * assumes the management frame decoder, the control register and the
 * negotiation engine all run on clk_i and give one-cycle pulses.
 */
// Behaviour
// R1: advertisement writes store at once; engine sees them after reset, restart, power-up or link loss
// R2: advertisement bit 13 writable, resets 0, sends local fault in base page
// R3: advertisement bit 12 writable, resets 1, declares extended next page ability
// R4: advertisement bits 11 and 10 writable pause abilities, both reset 1
// R5: advertisement bits 8..5 writable speed abilities reset 1; bit 9 reads zero
// R6: selector bits 4..0 writable, reset to the 802.3 pattern
// R7: partner base register holds received word, read-only, reset and soft reset clear
// R8: partner base bit 15 reports partner next page capability
// R9: partner base bits 13, 11, 10 show partner fault and pause requests
// R10: partner base bits 9..5 show partner technology abilities
// R11: expansion bit 4 latches parallel detection fault; read or soft reset clears
// R12: expansion bit 3 latches partner next page support; soft reset clears
// R13: expansion bit 2 reads one, local next page ability
// R14: expansion bit 1 latches on each received page; read clears
// R15: expansion bit 0 shows partner negotiation ability; bits 15..5 read zero
// R16: transmit next page bit 15 writable, resets 0, marks more pages follow
// R17: transmit next page bit 14 read-only zero
// R18: transmit next page bit 13 writable, resets 1, message versus unformatted
// R19: transmit next page bit 12 writable, resets 0, comply acknowledge
// R20: transmit next page bit 11 hardware toggle, inverse of previous exchanged word
// R21: transmit next page bits 10..0 writable, reset to one, message or unformatted code
// R22: partner next page bit 15 last-page flag, bit 14 mirrors received bit
// R23: partner next page bits 13..0 mirror received word, read-only
// R24: negotiation restarts after hardware or soft reset without the restart bit
// R25: writes to read-only or reserved fields are ignored
`timescale 1ns/10ps

module apr_regs
    import apr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire apr_mgmt_t   mgmt_i,
    input  wire apr_ctl_t    ctl_i,
    input  wire apr_rx_t     rx_i,
    output logic [15:0]      rdata_o,
    output logic             rvalid_o,
    output logic [15:0]      adv_word_o,
    output logic [15:0]      np_word_o,
    output logic             an_restart_o
);

    apr_state_t state_r;
    apr_state_t state_nxt;

    // keeps read-only bits, takes writable bits from the write data
    function automatic logic [15:0] masked_write(
        input logic [15:0] old_val,
        input logic [15:0] wval,
        input logic [15:0] mask
    );
        masked_write = (old_val & ~mask) | (wval & mask);
    endfunction : masked_write

    function automatic logic [15:0] exp_word(input apr_state_t s, input logic an_able);
        exp_word                   = APR_ZERO16;        // R15
        exp_word[APR_EXP_PD_FAULT] = s.pd_fault;        // R11
        exp_word[APR_EXP_LP_NP]    = s.lp_np_able;      // R12
        exp_word[APR_EXP_LOC_NP]   = 1'b1;              // R13
        exp_word[APR_EXP_PAGE_RX]  = s.page_rx;         // R14
        exp_word[APR_EXP_LP_AN]    = an_able;           // R15
    endfunction : exp_word

    logic wr_adv;
    logic wr_np;
    logic rd_exp;
    logic take_adv;

    always_comb begin
        wr_adv   = mgmt_i.wr && (mgmt_i.addr == APR_ADDR_ADV);
        wr_np    = mgmt_i.wr && (mgmt_i.addr == APR_ADDR_TX_NP);
        rd_exp   = mgmt_i.rd && (mgmt_i.addr == APR_ADDR_EXP);
        // any of these lets the engine pick up the stored advertisement
        take_adv = ctl_i.soft_reset | ctl_i.restart | ctl_i.pd_exit | ctl_i.link_down; // R1
    end

    always_comb begin
        state_nxt         = state_r;
        state_nxt.restart = 1'b0;
        state_nxt.rvalid  = 1'b0;

        // first cycle after hardware reset kicks the engine once
        if (!state_r.boot_done) begin
            state_nxt.boot_done = 1'b1;
            state_nxt.restart   = 1'b1;                  // R24
        end
        if (ctl_i.soft_reset || ctl_i.restart || ctl_i.pd_exit) begin
            state_nxt.restart = 1'b1;                    // R24
        end

        // advertisement: stored at once, ack and T4 bits stay zero
        if (wr_adv) begin
            state_nxt.adv = masked_write(state_r.adv, mgmt_i.wdata, APR_ADV_WMASK); // R1 R2 R3 R4 R5 R6 R25
        end
        // the write of the same cycle is already part of what the engine takes
        if (take_adv) begin
            state_nxt.adv_eff = state_nxt.adv;          // R1
        end

        if (wr_np) begin
            state_nxt.tx_np = masked_write(state_r.tx_np, mgmt_i.wdata, APR_NP_WMASK); // R16 R17 R18 R19 R21 R25
        end

        // toggle follows the word just exchanged
        if (rx_i.base_sent) begin
            state_nxt.toggle = ~state_r.adv_eff[APR_NP_TOGGLE]; // R20
        end else if (rx_i.np_sent) begin
            state_nxt.toggle = ~state_r.toggle;         // R20
        end

        // read-clear first, then hardware sets so a same-cycle event survives
        if (rd_exp) begin
            state_nxt.pd_fault = 1'b0;                  // R11
            state_nxt.page_rx  = 1'b0;                  // R14
        end
        if (rx_i.par_fault) begin
            state_nxt.pd_fault = 1'b1;                  // R11
        end
        if (rx_i.base_valid) begin
            state_nxt.lp_base = rx_i.word;              // R7 R8 R9 R10
            state_nxt.page_rx = 1'b1;                   // R14
            if (rx_i.word[APR_LP_NEXT_PAGE]) begin
                state_nxt.lp_np_able = 1'b1;            // R12
            end
        end
        if (rx_i.np_valid) begin
            state_nxt.lp_np   = rx_i.word;              // R22 R23
            state_nxt.page_rx = 1'b1;                   // R14
        end

        // soft reset wipes partner base page, fault and next page ability, overriding same-cycle captures
        if (ctl_i.soft_reset) begin
            state_nxt.lp_base    = APR_ZERO16;          // R7
            state_nxt.pd_fault   = 1'b0;                // R11
            state_nxt.lp_np_able = 1'b0;                // R12
        end

        // read data is one cycle behind the request; unmapped reads as zero
        if (mgmt_i.rd) begin
            state_nxt.rvalid = 1'b1;
            unique case (mgmt_i.addr)
                APR_ADDR_ADV:     state_nxt.rdata = state_r.adv;
                APR_ADDR_LP_BASE: state_nxt.rdata = state_r.lp_base;
                APR_ADDR_EXP:     state_nxt.rdata = exp_word(state_r, rx_i.an_able);
                APR_ADDR_TX_NP: begin
                    state_nxt.rdata                = state_r.tx_np;
                    state_nxt.rdata[APR_NP_TOGGLE] = state_r.toggle; // R20
                end
                APR_ADDR_LP_NP:   state_nxt.rdata = state_r.lp_np;
                default:          state_nxt.rdata = APR_ZERO16;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r.adv        <= APR_ADV_RESET;        // R2 R3 R4 R5 R6
            state_r.adv_eff    <= APR_ADV_RESET;
            state_r.lp_base    <= APR_ZERO16;           // R7
            state_r.lp_np      <= APR_ZERO16;           // R22
            state_r.tx_np      <= APR_NP_RESET;         // R16 R17 R18 R19 R21
            state_r.toggle     <= 1'b0;
            state_r.pd_fault   <= 1'b0;
            state_r.lp_np_able <= 1'b0;
            state_r.page_rx    <= 1'b0;
            state_r.rdata      <= APR_ZERO16;
            state_r.rvalid     <= 1'b0;
            state_r.restart    <= 1'b0;
            state_r.boot_done  <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_comb begin
        rdata_o                   = state_r.rdata;
        rvalid_o                  = state_r.rvalid;
        adv_word_o                = state_r.adv_eff;   // R2
        np_word_o                 = state_r.tx_np;
        np_word_o[APR_NP_TOGGLE]  = state_r.toggle;    // R20
        an_restart_o              = state_r.restart;   // R24
    end

endmodule : apr_regs

// *** dv/apr_regs_asserts.sv ***
/* apr_regs_asserts: port checker for apr_regs.
   assumes one clock and the synchronous active-high reset. */
`timescale 1ns/10ps
module apr_regs_asserts
    import apr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire apr_mgmt_t   mgmt_i,
    input  wire apr_ctl_t    ctl_i,
    input  wire apr_rx_t     rx_i,
    input  wire logic [15:0] rdata_o,
    input  wire logic        rvalid_o,
    input  wire logic [15:0] adv_word_o,
    input  wire logic [15:0] np_word_o,
    input  wire logic        an_restart_o
);
    logic kick;
    assign kick = ctl_i.soft_reset | ctl_i.restart | ctl_i.pd_exit;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    rd_answer_a: assert property (mgmt_i.rd |=> rvalid_o)
        else $error("read not answered");
    adv_hold_a: assert property (!(kick | ctl_i.link_down) |=> $stable(adv_word_o))
        else $error("advertisement moved without cause");
    restart_take_a: assert property (kick |=> an_restart_o)
        else $error("restart missing");
    // boot pulse lands one edge after the last reset edge and is sampled at the next
    restart_cause_a: assert property (an_restart_o |-> $past(kick) || $past(rst_i, 2))
        else $error("restart without cause");
    np_rsvd_a: assert property (np_word_o[14] == 1'b0)
        else $error("next page bit 14 set");
    adv_rsvd_a: assert property (adv_word_o[14] == 1'b0 && adv_word_o[9] == 1'b0)
        else $error("advertisement read-only bit set");
    exp_fixed_a: assert property (rvalid_o && $past(mgmt_i.addr) == APR_ADDR_EXP |->
        rdata_o[15:5] == 11'h000 && rdata_o[2] && rdata_o[0] == $past(rx_i.an_able))
        else $error("expansion fixed bits wrong");
    np_toggle_a: assert property (rx_i.np_sent |=> np_word_o[11] != $past(np_word_o[11]))
        else $error("toggle did not invert");
    base_toggle_a: assert property (rx_i.base_sent |=> np_word_o[11] == !$past(adv_word_o[11]))
        else $error("toggle not seeded from base page");
    unmapped_a: assert property (mgmt_i.rd && !(mgmt_i.addr inside {[APR_ADDR_ADV:APR_ADDR_LP_NP]})
        |=> rdata_o == 16'h0000) else $error("unmapped read not zero");

    cover property (rx_i.base_valid ##2 mgmt_i.rd);
    cover property (ctl_i.soft_reset ##1 an_restart_o);
    cover property (rx_i.np_sent ##2 mgmt_i.rd);
endmodule : apr_regs_asserts

bind apr_regs apr_regs_asserts u_apr_regs_asserts (.clk_i(clk_i), .rst_i(rst_i), .mgmt_i(mgmt_i), .ctl_i(ctl_i),
    .rx_i(rx_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .adv_word_o(adv_word_o), .np_word_o(np_word_o),
    .an_restart_o(an_restart_o));

// *** dv/apr_lp_model.sv ***
/* apr_lp_model: remote link partner delivering pages and exchange events.
   assumes the bench calls its tasks; drives on falling edges. */
`timescale 1ns/10ps
module apr_lp_model
    import apr_pkg::*;
(
    input  wire logic clk_i,
    output apr_rx_t   rx_o
);
    initial rx_o = '0;
    task automatic able(input logic a);
        rx_o.an_able = a;
    endtask : able
    // ev: 0 base page, 1 next page, 2 fault, 3 base sent, 4 next page sent; gap models a slow partner
    task automatic send(input int ev, input logic [15:0] w, input int gap);
        repeat (gap) @(negedge clk_i);
        @(negedge clk_i);
        rx_o.word       = w;
        rx_o.base_valid = (ev == 0);
        rx_o.np_valid   = (ev == 1);
        rx_o.par_fault  = (ev == 2);
        rx_o.base_sent  = (ev == 3);
        rx_o.np_sent    = (ev == 4);
        @(negedge clk_i);
        {rx_o.base_valid, rx_o.np_valid, rx_o.par_fault, rx_o.base_sent, rx_o.np_sent} = 5'h00;
        // stale word must not look valid
        rx_o.word = ~w;
    endtask : send
endmodule : apr_lp_model

// *** dv/apr_regs_test.sv ***
/* apr_regs_test: register-level test of apr_regs.
   assumes decoded management strobes and one 10 MHz clock. */
`timescale 1ns/10ps
module apr_regs_test
    import apr_pkg::*;
;
    logic        clk_i, rst_i, rvalid, restart, tg;
    apr_mgmt_t   mgmt;
    apr_ctl_t    ctl;
    apr_rx_t     rx;
    logic [15:0] rdata, adv_w, np_w, adv_exp, v;
    int          num_errors, check_count;

    apr_regs u_apr_regs (.clk_i(clk_i), .rst_i(rst_i), .mgmt_i(mgmt), .ctl_i(ctl), .rx_i(rx), .rdata_o(rdata),
        .rvalid_o(rvalid), .adv_word_o(adv_w), .np_word_o(np_w), .an_restart_o(restart));
    apr_lp_model u_apr_lp_model (.clk_i(clk_i), .rx_o(rx));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_i);
        mgmt = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_i);
        mgmt.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(negedge clk_i);
        mgmt = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clk_i);
        mgmt.rd = 1'b0;
        chk({15'h0000, rvalid}, 16'h0001);
        chk(rdata, exp);
    endtask : rd
    task automatic kick(input int k);
        @(negedge clk_i);
        ctl = apr_ctl_t'(4'b1000 >> k);
        @(negedge clk_i);
        ctl = '0;
    endtask : kick
    task automatic print_verdict();
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (3000) @(posedge clk_i);
        num_errors++;
        $display("FAIL %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        mgmt = '0;
        ctl = '0;
        rst_i = 1'b1;
        num_errors = 0;
        check_count = 0;
        adv_exp = 16'h1DE1;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        chk(adv_w, adv_exp);
        chk(np_w, 16'h2001);
        chk({15'h0000, restart}, 16'h0000);
        @(negedge clk_i);
        chk({15'h0000, restart}, 16'h0001);
        wr(APR_ADDR_LP_BASE, 16'hFFFF);
        wr(APR_ADDR_EXP, 16'hFFFF);
        wr(APR_ADDR_LP_NP, 16'hFFFF);
        rd(APR_ADDR_ADV, 16'h1DE1);
        rd(APR_ADDR_LP_BASE, 16'h0000);
        rd(APR_ADDR_EXP, 16'h0004);
        rd(APR_ADDR_TX_NP, 16'h2001);
        rd(APR_ADDR_LP_NP, 16'h0000);
        rd(5'h1F, 16'h0000);
        // each of the four causes makes the stored advertisement take effect
        for (int k = 0; k < 4; k++) begin
            v = 16'hFFFF >> (4 * k);
            wr(APR_ADDR_ADV, v);
            rd(APR_ADDR_ADV, v & APR_ADV_WMASK);
            chk(adv_w, adv_exp);
            kick(k);
            chk({15'h0000, restart}, {15'h0000, k != 3});
            adv_exp = v & APR_ADV_WMASK;
            chk(adv_w, adv_exp);
        end
        wr(APR_ADDR_TX_NP, 16'hFFFF);
        rd(APR_ADDR_TX_NP, 16'hB7FF);
        chk(np_w, 16'hB7FF);
        u_apr_lp_model.able(1'b1);
        u_apr_lp_model.send(0, 16'hAFE1, 0);
        rd(APR_ADDR_LP_BASE, 16'hAFE1);
        rd(APR_ADDR_EXP, 16'h000F);
        u_apr_lp_model.send(2, 16'h0000, 3);
        rd(APR_ADDR_EXP, 16'h001D);
        rd(APR_ADDR_EXP, 16'h000D);
        u_apr_lp_model.send(3, 16'h0000, 0);
        tg = ~adv_exp[11];
        rd(APR_ADDR_TX_NP, {4'hB, tg, 11'h7FF});
        chk(np_w, {4'hB, tg, 11'h7FF});
        u_apr_lp_model.send(4, 16'h0000, 2);
        rd(APR_ADDR_TX_NP, {4'hB, ~tg, 11'h7FF});
        chk(np_w, {4'hB, ~tg, 11'h7FF});
        u_apr_lp_model.send(1, 16'h8ABC, 1);
        rd(APR_ADDR_LP_NP, 16'h8ABC);
        rd(APR_ADDR_EXP, 16'h000F);
        kick(0);
        chk({15'h0000, restart}, 16'h0001);
        chk(adv_w, adv_exp);
        rd(APR_ADDR_LP_BASE, 16'h0000);
        rd(APR_ADDR_EXP, 16'h0005);
        rd(APR_ADDR_LP_NP, 16'h8ABC);
        print_verdict();
    end
endmodule : apr_regs_test
